// ==== design/amp_regs_pkg.sv ====
// constants for the fault, clip and filter control register group
//
// Behaviour
// - writing 1 to bit 7 clears latched faults
// - bit 6 picks parallel-bridge signal source
// - bit 5 set hides current-limit from warning
// - bit 3 picks latched or automatic thermal recovery
// - clip detect enable bit, resets enabled
// - eight-bit clip window field, resets 00010100
// - per-channel clip flags, read only
// - per-channel current-limit flags, read only
// - three-bit high-pass corner, upper bits reset 01000
// - mismatched paralleled channel states raise a fault
// - parallel-bridge commands act only in standby
// - load diagnostic allowed on parallel pair
// - device is bus target only, never clocks
// - tdm-only control bits ignored in other formats
// - switching ratios 38/44/48 or 8/10 times
// - accepts four formats, 16/18/20/24/32 bits, three rates
// - line-driver mode selected per channel
// - clip warning shown unless clip mask set
package amp_regs_pkg;
   // register offsets on the serial control bus
   localparam logic [7:0] OFF_MISC3 = 8'h21;
   localparam logic [7:0] OFF_CLIP_CTRL = 8'h22;
   localparam logic [7:0] OFF_CLIP_WIN = 8'h23;
   localparam logic [7:0] OFF_CLIP_FLAGS = 8'h24;
   localparam logic [7:0] OFF_ILIM_FLAGS = 8'h25;
   localparam logic [7:0] OFF_HPF = 8'h26;
   // reset values
   localparam logic [7:0] RST_MISC3 = 8'h00;
   localparam logic [7:0] RST_CLIP_CTRL = 8'h01;
   localparam logic [7:0] RST_CLIP_WIN = 8'h14;
   localparam logic [7:0] RST_HPF = 8'h40;
   // field positions
   localparam int BIT_CLEAR_FAULT = 7;
   localparam int BIT_PAR_SRC = 6;
   localparam int BIT_ILIM_MASK = 5;
   localparam int BIT_AUTO_RECOVER = 3;
   localparam int BIT_CLIP_EN = 0;
   localparam logic [7:0] MISC3_STORED = 8'h78; // bits 6..3 hold state
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   localparam logic [7:0] NOT_READY_DATA = 8'hff;
   // bus target address, value arbitrary
   localparam logic [6:0] DEV_ADDR_DFLT = 7'h6a;
   // switching frequency ratios to sample rate
   localparam logic [5:0] FSW_38 = 6'h26;
   localparam logic [5:0] FSW_44 = 6'h2c;
   localparam logic [5:0] FSW_48 = 6'h30;
   localparam logic [5:0] FSW_8 = 6'h08;
   localparam logic [5:0] FSW_10 = 6'h0a;
   // serial audio input limits
   localparam logic [1:0] FMT_TDM = 2'h3;
   localparam logic [1:0] RATE_CODE_MAX = 2'h2;
   localparam logic [5:0] WL_16 = 6'h10;
   localparam logic [5:0] WL_18 = 6'h12;
   localparam logic [5:0] WL_20 = 6'h14;
   localparam logic [5:0] WL_24 = 6'h18;
   localparam logic [5:0] WL_32 = 6'h20;
   // link byte sequencing
   typedef enum logic [2:0] {LS_IDLE, LS_ADDR, LS_REG, LS_WDATA, LS_RDATA} link_state_t;
endpackage

// ==== design/dual_flop_sync.sv ====
// two-flop level synchroniser, one per bit
`timescale 1ns/1ns
module dual_flop_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   if (W < 1) begin : bad_width
      $error("dual_flop_sync needs W of at least 1");
   end

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // dual_flop_sync

// ==== design/amp_fault_clip_control_regs.sv ====
// fault clear, clip detect, current-limit and filter control registers behind the bus target
`timescale 1ns/1ns
module amp_fault_clip_control_regs #(
   parameter logic [6:0] DEV_ADDR = amp_regs_pkg::DEV_ADDR_DFLT
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic bus_clk,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [1:0] clip_evt,
   input wire logic [1:0] ilim_evt,
   input wire logic thermal_evt,
   input wire logic standby,
   input wire logic parallel_req,
   input wire logic [1:0] ch1_state,
   input wire logic [1:0] ch2_state,
   input wire logic clip_warn_mask,
   input wire logic diag_req,
   input wire logic [1:0] sap_format,
   input wire logic [2:0] sap_tdm_bits,
   input wire logic [5:0] sap_word_bits,
   input wire logic [1:0] sap_rate_sel,
   input wire logic [2:0] fsw_sel,
   input wire logic [1:0] line_drv_cfg,
   output logic fault_b,
   output logic warn_b,
   output logic parallel_bridge_mode,
   output logic parallel_source_select,
   output logic thermal_shutdown,
   output logic clip_detect_enable,
   output logic [7:0] clip_window,
   output logic [2:0] highpass_corner_select,
   output logic diag_pair_enable,
   output logic [2:0] sap_tdm_bits_eff,
   output logic [5:0] fsw_ratio,
   output logic sap_format_ok,
   output logic [1:0] line_drv_mode
);
   import amp_regs_pkg::*;

   if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : bad_addr
      $error("DEV_ADDR falls in a reserved bus address range");
   end

   // ---------------- link side, clocked by the bus clock ----------------
   link_state_t st_r;
   logic start_tgl_r, start_ack_r;
   logic [3:0] cnt_r;
   logic [6:0] rx_r;
   logic [7:0] tx_r;
   logic ack_me_r;
   logic [7:0] ptr_r, wr_addr_r, wr_data_r;
   logic wr_tgl_r, rd_req_r;
   logic sda_o_r, sda_oe_r;
   logic rd_ack_r, rd_ack_s;
   logic [7:0] rd_hold_r;

   // start means sda falls while bus clock is high; the bus clock stands
   // still between frames, so the data line is the only edge to catch it
   always_ff @(negedge sda_i or negedge rst_b) begin
      if (!rst_b) begin
         start_tgl_r <= 1'b0;
      end else if (bus_clk) begin
         start_tgl_r <= ~start_tgl_r;
      end
   end

   wire start_pend = start_tgl_r ^ start_ack_r;
   wire [7:0] rx_byte = {rx_r, sda_i};
   wire byte_done = cnt_r == 4'h7;
   wire addr_hit = rx_byte[7:1] == DEV_ADDR;
   wire rd_valid = rd_ack_s == rd_req_r;
   wire [7:0] rd_byte = rd_valid ? rd_hold_r : NOT_READY_DATA;

   // read answers come back as a level copy of the request
   dual_flop_sync #(.W(1)) u_ack_sync (
      .clk(bus_clk),
      .rst_b(rst_b),
      .d(rd_ack_r),
      .q(rd_ack_s)
   );

   // sample side: bits taken on the rising bus clock
   always_ff @(posedge bus_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= LS_IDLE;
         start_ack_r <= 1'b0;
         cnt_r <= 4'h0;
         rx_r <= 7'h00;
         ack_me_r <= 1'b0;
         ptr_r <= 8'h00;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
         wr_tgl_r <= 1'b0;
         rd_req_r <= 1'b0;
      end else if (start_pend) begin
         // repeated start aborts any byte in flight
         start_ack_r <= start_tgl_r;
         st_r <= LS_ADDR;
         rx_r <= {6'h00, sda_i};
         cnt_r <= 4'h1;
         ack_me_r <= 1'b0;
      end else if (st_r != LS_IDLE) begin
         if (cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            if (st_r == LS_RDATA && sda_i) begin
               st_r <= LS_IDLE; // master refused the byte
            end
         end else begin
            rx_r <= rx_byte[6:0];
            cnt_r <= cnt_r + 4'h1;
            // prefetch next read byte a whole byte ahead of need
            if (st_r == LS_RDATA && cnt_r == 4'h0) begin
               ptr_r <= ptr_r + 8'h01;
               rd_req_r <= ~rd_req_r;
            end
            if (byte_done) begin
               case (st_r)
                  LS_ADDR: begin
                     ack_me_r <= addr_hit;
                     if (!addr_hit) begin
                        st_r <= LS_IDLE;
                     end else if (rx_byte[0]) begin
                        st_r <= LS_RDATA;
                     end else begin
                        st_r <= LS_REG;
                     end
                  end
                  LS_REG: begin
                     ack_me_r <= 1'b1;
                     ptr_r <= rx_byte;
                     rd_req_r <= ~rd_req_r;
                     st_r <= LS_WDATA;
                  end
                  LS_WDATA: begin
                     ack_me_r <= 1'b1;
                     wr_addr_r <= ptr_r;
                     wr_data_r <= rx_byte;
                     wr_tgl_r <= ~wr_tgl_r;
                     ptr_r <= ptr_r + 8'h01;
                     rd_req_r <= ~rd_req_r;
                  end
                  default: begin
                     ack_me_r <= 1'b0;
                  end
               endcase
            end
         end
      end
   end

   // drive side: open-drain data changes only while the bus clock is low;
   // the bus clock itself is never driven and no frame is ever begun here
   always_ff @(negedge bus_clk or negedge rst_b) begin
      if (!rst_b) begin
         sda_o_r <= 1'b0;
         sda_oe_r <= 1'b0;
         tx_r <= 8'hff;
      end else begin
         sda_o_r <= 1'b0;
         if (cnt_r == 4'h8) begin
            sda_oe_r <= ack_me_r;
         end else if (st_r == LS_RDATA) begin
            if (cnt_r == 4'h0) begin
               tx_r <= {rd_byte[6:0], 1'b1};
               sda_oe_r <= ~rd_byte[7];
            end else begin
               tx_r <= {tx_r[6:0], 1'b1};
               sda_oe_r <= ~tx_r[7];
            end
         end else begin
            sda_oe_r <= 1'b0;
         end
      end
   end

   assign sda_o = sda_o_r;
   assign sda_oe = sda_oe_r;

   // ---------------- core side, clocked by clk ----------------
   logic wr_tgl_s, rd_req_s, wr_seen_r;
   logic [4:0] ev_s;
   logic [7:0] misc3_r, clip_ctrl_r, clip_win_r, hpf_r;
   logic [1:0] clip_flag_r, ilim_flag_r;
   logic therm_r, pbr_mode_r, pbr_fault_r;
   logic fault_b_r, warn_b_r, diag_pair_r, fmt_ok_r;
   logic [2:0] sap_tdm_r;
   logic [5:0] fsw_r;
   logic [1:0] line_drv_r;

   dual_flop_sync #(.W(1)) u_wr_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(wr_tgl_r),
      .q(wr_tgl_s)
   );

   dual_flop_sync #(.W(1)) u_rd_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(rd_req_r),
      .q(rd_req_s)
   );

   // analog event detectors run unrelated to clk
   dual_flop_sync #(.W(5)) u_evt_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({thermal_evt, ilim_evt, clip_evt}),
      .q(ev_s)
   );

   // write decode; address and data stay put until the next toggle
   wire wr_stb = wr_tgl_s ^ wr_seen_r;
   wire wr_misc3 = wr_stb && wr_addr_r == OFF_MISC3;
   wire wr_clip_ctrl = wr_stb && wr_addr_r == OFF_CLIP_CTRL;
   wire wr_clip_win = wr_stb && wr_addr_r == OFF_CLIP_WIN;
   wire wr_hpf = wr_stb && wr_addr_r == OFF_HPF;
   wire clear_pulse = wr_misc3 && wr_data_r[BIT_CLEAR_FAULT];
   wire clip_en = clip_ctrl_r[BIT_CLIP_EN];
   wire auto_rec = misc3_r[BIT_AUTO_RECOVER];
   wire therm_s = ev_s[4];
   wire pbr_mismatch = pbr_mode_r && (ch1_state != ch2_state);

   // sticky flags: a new event beats a clear in the same cycle
   wire [1:0] clip_set = ev_s[1:0] & {2{clip_en}};
   wire [1:0] clip_nxt = clip_set | (clear_pulse ? 2'b00 : clip_flag_r);
   wire [1:0] ilim_nxt = ev_s[3:2] | (clear_pulse ? 2'b00 : ilim_flag_r);
   wire therm_hold = therm_s | (therm_r & ~clear_pulse);
   wire therm_nxt = auto_rec ? therm_s : therm_hold;
   wire pbr_fault_nxt = pbr_mismatch | (pbr_fault_r & ~clear_pulse);
   wire warn_clip = (|clip_flag_r) & ~clip_warn_mask;
   wire warn_ilim = (|ilim_flag_r) & ~misc3_r[BIT_ILIM_MASK];

   // read mux; holes in the map read as zero
   wire [7:0] rd_mux =
      (ptr_r == OFF_MISC3) ? (misc3_r & MISC3_STORED) :
      (ptr_r == OFF_CLIP_CTRL) ? clip_ctrl_r :
      (ptr_r == OFF_CLIP_WIN) ? clip_win_r :
      (ptr_r == OFF_CLIP_FLAGS) ? {6'h00, clip_flag_r} :
      (ptr_r == OFF_ILIM_FLAGS) ? {6'h00, ilim_flag_r} :
      (ptr_r == OFF_HPF) ? hpf_r : UNMAPPED_DATA;

   // switching ratio and input format checks
   wire [5:0] fsw_nxt =
      (fsw_sel == 3'h0) ? FSW_38 :
      (fsw_sel == 3'h1) ? FSW_44 :
      (fsw_sel == 3'h2) ? FSW_48 :
      (fsw_sel == 3'h3) ? FSW_8 :
      (fsw_sel == 3'h4) ? FSW_10 : FSW_44;
   wire wl_ok = sap_word_bits == WL_16 || sap_word_bits == WL_18 ||
      sap_word_bits == WL_20 || sap_word_bits == WL_24 || sap_word_bits == WL_32;
   wire fmt_ok_nxt = wl_ok && sap_rate_sel <= RATE_CODE_MAX;

   // crossing bookkeeping
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_seen_r <= 1'b0;
         rd_ack_r <= 1'b0;
         rd_hold_r <= 8'h00;
      end else begin
         wr_seen_r <= wr_tgl_s;
         if (rd_req_s != rd_ack_r) begin
            rd_hold_r <= rd_mux;
            rd_ack_r <= rd_req_s;
         end
      end
   end

   // control registers; the clear bit is never stored so it reads 0
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         misc3_r <= RST_MISC3;
         clip_ctrl_r <= RST_CLIP_CTRL;
         clip_win_r <= RST_CLIP_WIN;
         hpf_r <= RST_HPF;
      end else begin
         if (wr_misc3) misc3_r <= wr_data_r & MISC3_STORED;
         if (wr_clip_ctrl) clip_ctrl_r <= {7'h00, wr_data_r[BIT_CLIP_EN]};
         if (wr_clip_win) clip_win_r <= wr_data_r;
         if (wr_hpf) hpf_r <= wr_data_r;
      end
   end

   // status flags and fault latches
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clip_flag_r <= 2'b00;
         ilim_flag_r <= 2'b00;
         therm_r <= 1'b0;
         pbr_fault_r <= 1'b0;
      end else begin
         clip_flag_r <= clip_nxt;
         ilim_flag_r <= ilim_nxt;
         therm_r <= therm_nxt;
         pbr_fault_r <= pbr_fault_nxt;
      end
   end

   // pins and mode outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_b_r <= 1'b1;
         warn_b_r <= 1'b1;
         pbr_mode_r <= 1'b0;
         diag_pair_r <= 1'b0;
         sap_tdm_r <= 3'h0;
         fsw_r <= FSW_44;
         fmt_ok_r <= 1'b0;
         line_drv_r <= 2'b00;
      end else begin
         fault_b_r <= ~(therm_r | pbr_fault_r);
         warn_b_r <= ~(warn_clip | warn_ilim);
         if (standby) pbr_mode_r <= parallel_req;
         diag_pair_r <= pbr_mode_r & diag_req;
         sap_tdm_r <= (sap_format == FMT_TDM) ? sap_tdm_bits : 3'h0;
         fsw_r <= fsw_nxt;
         fmt_ok_r <= fmt_ok_nxt;
         line_drv_r <= line_drv_cfg;
      end
   end

   assign fault_b = fault_b_r;
   assign warn_b = warn_b_r;
   assign parallel_bridge_mode = pbr_mode_r;
   assign parallel_source_select = misc3_r[BIT_PAR_SRC];
   assign thermal_shutdown = therm_r;
   assign clip_detect_enable = clip_ctrl_r[BIT_CLIP_EN];
   assign clip_window = clip_win_r;
   assign highpass_corner_select = hpf_r[2:0];
   assign diag_pair_enable = diag_pair_r;
   assign sap_tdm_bits_eff = sap_tdm_r;
   assign fsw_ratio = fsw_r;
   assign sap_format_ok = fmt_ok_r;
   assign line_drv_mode = line_drv_r;

   // ---------------- checks on the core side ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence misc_wr_s;
      wr_stb && wr_addr_r == OFF_MISC3;
   endsequence

   sequence clear_quiet_s;
      misc_wr_s ##0 wr_data_r[BIT_CLEAR_FAULT] && ev_s[3:0] == 4'h0 && !pbr_mismatch;
   endsequence

   fault_clear_a: assert property (clear_quiet_s |=> !pbr_fault_r && clip_flag_r == 2'b00)
      else $error("fault clear left a latched flag");
   one_shot_a: assert property (clear_quiet_s |=> ilim_flag_r == 2'b00 && !clear_pulse)
      else $error("fault clear bit did not act once");
   source_sel_a: assert property (misc_wr_s |=> parallel_source_select == $past(wr_data_r[6]))
      else $error("parallel source select not taken from write");
   ilim_warn_a: assert property (warn_ilim |=> !warn_b_r)
      else $error("current-limit warning not on pin");
   auto_rec_a: assert property (auto_rec && !therm_s ##1 auto_rec |-> !therm_r)
      else $error("thermal fault did not recover");
   latch_hold_a: assert property (!auto_rec && therm_r && !clear_pulse |=> therm_r)
      else $error("thermal fault lost while latched");
   clip_off_a: assert property ((!clip_en && clip_flag_r == 2'b00 && !wr_clip_ctrl) [*2]
      |=> clip_flag_r == 2'b00)
      else $error("clip flag rose with detection off");
   window_wr_a: assert property (wr_clip_win |=> clip_win_r == $past(wr_data_r))
      else $error("clip window not written");
   clip_set_a: assert property (clip_en && ev_s[1] |=> clip_flag_r[1])
      else $error("clip flag missed an event");
   ilim_set_a: assert property (ev_s[2] ##1 !misc3_r[BIT_ILIM_MASK] |-> ilim_flag_r[0] ##1 !warn_b_r)
      else $error("current-limit flag missed an event");
   mismatch_a: assert property (pbr_mismatch |-> ##2 !fault_b_r)
      else $error("channel state mismatch not reported");
   standby_a: assert property (!standby |=> $stable(pbr_mode_r))
      else $error("parallel mode changed outside standby");
   clip_pin_a: assert property (warn_clip |=> !warn_b_r)
      else $error("clip warning not on pin");
endmodule // amp_fault_clip_control_regs

// ==== dv/bus_master_model.sv ====
// serial bus master model for the control link of the register group
`timescale 1ns/1ns
module bus_master_model #(
   parameter logic [6:0] DEV_ADDR = 7'h6a
) (
   output logic scl,
   output logic sda_low,
   input wire logic sda_line
);
   logic in_frame = 1'b0;
   // clock idles high between frames; only this side ever clocks the link
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // one 125 ns bit slot; data moves only while the clock is low, sampled at the rise
   task automatic bit_slot(input logic b, output logic got);
      scl = 1'b0;
      #31 sda_low = !b;
      #31 scl = 1'b1;
      got = sda_line;
      #63;
   endtask
   // start, or repeated start when already inside a frame
   task automatic start_cond;
      if (in_frame) begin
         scl = 1'b0;
         #31 sda_low = 1'b0;
         #31 scl = 1'b1;
      end
      #31 sda_low = 1'b1;
      #32 in_frame = 1'b1;
   endtask
   // stop leaves both lines released and the clock standing high
   task automatic stop_cond;
      scl = 1'b0;
      #31 sda_low = 1'b1;
      #31 scl = 1'b1;
      #31 sda_low = 1'b0;
      #32 in_frame = 1'b0;
   endtask
   // eight bits msb first, then the ack slot with the line released
   task automatic put_byte(input logic [7:0] v, inout logic ok);
      logic g;
      for (int i = 7; i >= 0; i--) bit_slot(v[i], g);
      bit_slot(1'b1, g);
      ok = ok & !g;
   endtask
   // address, pointer and one data byte in a single frame
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, d, output logic ok);
      ok = 1'b1;
      start_cond();
      put_byte({dev, 1'b0}, ok);
      put_byte(ptr, ok);
      put_byte(d, ok);
      stop_cond();
   endtask
   // pointer write, repeated start, one byte back and a nack
   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
      logic g;
      ok = 1'b1;
      start_cond();
      put_byte({DEV_ADDR, 1'b0}, ok);
      put_byte(ptr, ok);
      start_cond();
      put_byte({DEV_ADDR, 1'b1}, ok);
      for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
      bit_slot(1'b1, g);
      stop_cond();
   endtask
endmodule // bus_master_model

// ==== dv/amp_fault_clip_control_regs_tb.sv ====
// self-checking bench for the fault, clip and filter register group
`timescale 1ns/1ns
module amp_fault_clip_control_regs_tb;
   import amp_regs_pkg::*;
   logic clk, rst_b, bus_clk, sda_low, sda_o, sda_oe, sda_line;
   logic [1:0] clip_evt, ilim_evt, ch1_state, ch2_state, sap_format, sap_rate_sel, line_drv_cfg;
   logic thermal_evt, standby, parallel_req, clip_warn_mask, diag_req;
   logic [2:0] sap_tdm_bits, fsw_sel, highpass_corner_select, sap_tdm_bits_eff;
   logic [5:0] sap_word_bits, fsw_ratio;
   logic fault_b, warn_b, parallel_bridge_mode, parallel_source_select, thermal_shutdown;
   logic clip_detect_enable, diag_pair_enable, sap_format_ok;
   logic [7:0] clip_window;
   logic [1:0] line_drv_mode;
   logic [5:0] ratio_tbl [5] = '{FSW_38, FSW_44, FSW_48, FSW_8, FSW_10};
   int fail_count = 0;
   int n_compared = 0;
   // open-drain data line with pull-up
   assign sda_line = !(sda_low || (sda_oe && !sda_o));
   amp_fault_clip_control_regs dut (.clk, .rst_b, .bus_clk, .sda_i(sda_line), .sda_o, .sda_oe,
      .clip_evt, .ilim_evt, .thermal_evt, .standby, .parallel_req, .ch1_state, .ch2_state,
      .clip_warn_mask, .diag_req, .sap_format, .sap_tdm_bits, .sap_word_bits, .sap_rate_sel,
      .fsw_sel, .line_drv_cfg, .fault_b, .warn_b, .parallel_bridge_mode,
      .parallel_source_select, .thermal_shutdown, .clip_detect_enable, .clip_window,
      .highpass_corner_select, .diag_pair_enable, .sap_tdm_bits_eff, .fsw_ratio,
      .sap_format_ok, .line_drv_mode);
   bus_master_model #(.DEV_ADDR(DEV_ADDR_DFLT)) m (.scl(bus_clk), .sda_low, .sda_line);
   // core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, exp, input string what);
      chk_byte({7'h00, got}, {7'h00, exp}, what);
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic ok;
      m.write_reg(DEV_ADDR_DFLT, a, d, ok);
      chk_bit(ok, 1'b1, "write ack");
      wait_clk(2);
   endtask
   task automatic rd(input logic [7:0] a, exp);
      logic [7:0] d;
      logic ok;
      m.read_reg(a, d, ok);
      chk_bit(ok, 1'b1, "read ack");
      chk_byte(d, exp, "read data");
   endtask
   // event levels pass two sync flops, a flag and a pin stage
   task automatic pulse(input logic [1:0] c, i, input logic t);
      @(posedge clk);
      clip_evt <= c;
      ilim_evt <= i;
      thermal_evt <= t;
      wait_clk(6);
      clip_evt <= 2'b00;
      ilim_evt <= 2'b00;
      thermal_evt <= 1'b0;
      wait_clk(6);
   endtask
   task automatic t_reset_vals;
      rd(OFF_MISC3, 8'h00);
      rd(OFF_CLIP_CTRL, 8'h01);
      rd(OFF_CLIP_WIN, 8'h14);
      rd(OFF_CLIP_FLAGS, 8'h00);
      rd(OFF_ILIM_FLAGS, 8'h00);
      rd(OFF_HPF, 8'h40);
      rd(8'h30, 8'h00);
   endtask
   task automatic t_misc3;
      wr(OFF_MISC3, 8'hff);
      chk_bit(parallel_source_select, 1'b1, "source");
      rd(OFF_MISC3, 8'h78);
      wr(OFF_MISC3, 8'h00);
      chk_bit(parallel_source_select, 1'b0, "source");
      wr(OFF_CLIP_FLAGS, 8'hff);
      rd(OFF_CLIP_FLAGS, 8'h00);
   endtask
   task automatic t_clip;
      pulse(2'b10, 2'b00, 1'b0);
      chk_bit(warn_b, 1'b0, "clip warn");
      rd(OFF_CLIP_FLAGS, 8'h02);
      @(posedge clk) clip_warn_mask <= 1'b1;
      wait_clk(4);
      chk_bit(warn_b, 1'b1, "clip masked");
      @(posedge clk) clip_warn_mask <= 1'b0;
      wr(OFF_MISC3, 8'h80);
      rd(OFF_CLIP_FLAGS, 8'h00);
      chk_bit(warn_b, 1'b1, "cleared");
      wr(OFF_CLIP_CTRL, 8'h00);
      chk_bit(clip_detect_enable, 1'b0, "clip off");
      pulse(2'b01, 2'b00, 1'b0);
      rd(OFF_CLIP_FLAGS, 8'h00);
      wr(OFF_CLIP_CTRL, 8'h01);
   endtask
   task automatic t_ilim;
      wr(OFF_MISC3, 8'h20);
      pulse(2'b00, 2'b01, 1'b0);
      chk_bit(warn_b, 1'b1, "ilim masked");
      rd(OFF_ILIM_FLAGS, 8'h01);
      wr(OFF_MISC3, 8'h00);
      wait_clk(3);
      chk_bit(warn_b, 1'b0, "ilim warn");
      wr(OFF_MISC3, 8'h80);
      rd(OFF_ILIM_FLAGS, 8'h00);
   endtask
   task automatic t_thermal;
      pulse(2'b00, 2'b00, 1'b1);
      chk_bit(thermal_shutdown, 1'b1, "latched");
      chk_bit(fault_b, 1'b0, "fault pin");
      wr(OFF_MISC3, 8'h80);
      chk_bit(thermal_shutdown, 1'b0, "cleared");
      wr(OFF_MISC3, 8'h08);
      @(posedge clk) thermal_evt <= 1'b1;
      wait_clk(6);
      chk_bit(thermal_shutdown, 1'b1, "auto on");
      pulse(2'b00, 2'b00, 1'b0);
      chk_bit(thermal_shutdown, 1'b0, "auto off");
      wr(OFF_MISC3, 8'h00);
   endtask
   // bridge requests outside standby are sent on purpose and must not land
   task automatic t_parallel;
      @(posedge clk) parallel_req <= 1'b1;
      wait_clk(3);
      chk_bit(parallel_bridge_mode, 1'b0, "no standby");
      standby <= 1'b1;
      wait_clk(3);
      standby <= 1'b0;
      wait_clk(2);
      chk_bit(parallel_bridge_mode, 1'b1, "standby");
      ch2_state <= 2'b10;
      wait_clk(4);
      ch2_state <= ch1_state;
      diag_req <= 1'b1;
      wait_clk(4);
      chk_bit(fault_b, 1'b0, "mismatch");
      chk_bit(diag_pair_enable, 1'b1, "pair diag");
      wr(OFF_MISC3, 8'h80);
      chk_bit(fault_b, 1'b1, "mismatch cleared");
   endtask
   task automatic t_pins;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk) fsw_sel <= 3'(i);
         wait_clk(3);
         chk_byte({2'b00, fsw_ratio}, {2'b00, ratio_tbl[i]}, "ratio");
      end
      for (int f = 0; f < 4; f++) begin
         @(posedge clk) sap_format <= 2'(f);
         wait_clk(3);
         chk_byte({5'h00, sap_tdm_bits_eff}, (f == 3) ? 8'h05 : 8'h00, "tdm bits");
         chk_bit(sap_format_ok, 1'b1, "format");
      end
      sap_rate_sel <= 2'h3;
      line_drv_cfg <= 2'b10;
      wait_clk(3);
      chk_bit(sap_format_ok, 1'b0, "bad rate");
      chk_byte({6'h00, line_drv_mode}, 8'h02, "line drv");
      wr(OFF_HPF, 8'h47);
      chk_byte({5'h00, highpass_corner_select}, 8'h07, "corner");
      rd(OFF_HPF, 8'h47);
      wr(OFF_CLIP_WIN, 8'ha5);
      chk_byte(clip_window, 8'ha5, "window");
   endtask
   task automatic t_wrong_addr;
      logic ok;
      m.write_reg(DEV_ADDR_DFLT ^ 7'h01, OFF_CLIP_WIN, 8'h3c, ok);
      chk_bit(ok, 1'b0, "foreign ack");
      rd(OFF_CLIP_WIN, 8'ha5);
   endtask
   initial begin
      {clip_evt, ilim_evt, thermal_evt, standby, parallel_req, diag_req} = '0;
      {ch1_state, ch2_state, clip_warn_mask, sap_format, fsw_sel, line_drv_cfg} = '0;
      sap_tdm_bits = 3'h5;
      sap_word_bits = WL_24;
      sap_rate_sel = 2'h1;
      rst_b = 1'b0;
      wait_clk(4);
      chk_bit(clip_detect_enable, 1'b1, "reset enable");
      chk_byte(clip_window, 8'h14, "reset window");
      chk_bit(warn_b, 1'b1, "reset warn");
      wait_clk(1);
      rst_b <= 1'b1;
      wait_clk(3);
      t_reset_vals();
      t_misc3();
      t_clip();
      t_ilim();
      t_thermal();
      t_parallel();
      t_pins();
      t_wrong_addr();
      close_out();
   end
   // hang guard, far beyond the expected run
   initial begin
      #500000;
      fail_count++;
      $display("ERROR at %0t: timeout", $time);
      close_out();
   end
endmodule // amp_fault_clip_control_regs_tb
